//--- core/compare_match_consts.svh
// constants for the compare match unit: offsets, fields, mode codes
`ifndef COMPARE_MATCH_CONSTS_SVH
`define COMPARE_MATCH_CONSTS_SVH

// ==========================================
// register byte addresses
`define OFS_IRQ_FLAGS      8'h00
`define OFS_IRQ_ENABLES    8'h04
`define OFS_IRQ_PRIORITIES 8'h08
`define OFS_TA_COUNT_LOW   8'h0C
`define OFS_TA_COUNT_HIGH  8'h10
`define OFS_TA_CONTROL     8'h14
`define OFS_TB_COUNT_HIGH  8'h18
`define OFS_TB_COUNT_LOW   8'h1C
`define OFS_TB_CONTROL     8'h20
`define OFS_U1_VALUE_LOW   8'h24
`define OFS_U1_VALUE_HIGH  8'h28
`define OFS_U1_CONTROL     8'h2C
`define OFS_U2_VALUE_LOW   8'h30
`define OFS_U2_VALUE_HIGH  8'h34
`define OFS_U2_CONTROL     8'h38
`define OFS_MOD_PERIOD     8'h3C
`define OFS_MOD_COUNT      8'h40
`define OFS_MOD_CONTROL    8'h44

// ==========================================
// field positions
`define BIT_U1_IRQ         1
`define BIT_U2_IRQ         2
`define IRQ_IMPL_MASK      8'h06
`define BIT_TIMER_ON       0
`define BIT_SEL_HI         6
`define BIT_SEL_LO         3
`define CTL_IMPL_MASK      8'h3F
`define BIT_MOD_ON         0

// ==========================================
// mode field codes and reset values
`define MODE_OFF           4'h0
`define MODE_TOGGLE        4'h2
`define MODE_SET_HIGH      4'h8
`define MODE_SET_LOW       4'h9
`define MODE_SW_IRQ        4'hA
`define MODE_SPECIAL       4'hB
`define RST_BYTE           8'h00
`define RST_PERIOD         8'hFF
`define SUB_LAST           2'h3

`endif

//--- core/compare_match_pkg.sv
// types shared by the compare match unit
`default_nettype none
package compare_match_pkg;
	`include "compare_match_consts.svh"

	// the mode field of a unit control register
	typedef enum logic [3:0] {
		MODE_OFF_E      = `MODE_OFF,
		MODE_TOGGLE_E   = `MODE_TOGGLE,
		MODE_SET_HIGH_E = `MODE_SET_HIGH,
		MODE_SET_LOW_E  = `MODE_SET_LOW,
		MODE_SW_IRQ_E   = `MODE_SW_IRQ,
		MODE_SPECIAL_E  = `MODE_SPECIAL
	} mode_t;

	typedef logic [7:0]  byte_t;
	typedef logic [15:0] count_t;
endpackage : compare_match_pkg
`default_nettype wire

//--- core/compare_match_unit.sv
// two compare units with special event trigger and a 10-bit modulator on unit two
`default_nettype none
`include "compare_match_consts.svh"

module compare_match_unit (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rstn_in,
	input  wire logic [7:0]               paddr_in,
	input  wire logic                     psel_in,
	input  wire logic                     penable_in,
	input  wire logic                     pwrite_in,
	input  wire logic [31:0]              pwdata_in,
	output logic      [31:0]              prdata_out,
	output logic                          pready_out,
	output logic                          pslverr_out,
	input  wire logic [1:0]               gpio_latch_in,
	input  wire logic                     adc_enabled_in,
	output logic                          adc_start_out,
	output logic      [1:0]               match_pin_out,
	output logic      [1:0]               special_trigger_out,
	output logic                          irq_out
);
	import compare_match_pkg::*;

	// ==========================================
	// apb decode
	// every access is answered in its first access cycle
	wire logic   acc       = psel_in & penable_in;
	wire logic   wr        = acc & pwrite_in;
	wire byte_t  wd        = pwdata_in[7:0];
	wire logic   wr_flags  = wr & (paddr_in == `OFS_IRQ_FLAGS);
	wire logic   wr_ena    = wr & (paddr_in == `OFS_IRQ_ENABLES);
	wire logic   wr_pri    = wr & (paddr_in == `OFS_IRQ_PRIORITIES);
	wire logic   wr_mper   = wr & (paddr_in == `OFS_MOD_PERIOD);
	wire logic   wr_mcnt   = wr & (paddr_in == `OFS_MOD_COUNT);
	wire logic   wr_mctl   = wr & (paddr_in == `OFS_MOD_CONTROL);
	logic [1:0]  wr_tlo;
	logic [1:0]  wr_thi;
	logic [1:0]  wr_tctl;
	logic [1:0]  wr_vlo;
	logic [1:0]  wr_vhi;
	logic [1:0]  wr_uctl;
	assign wr_tlo  = {wr & (paddr_in == `OFS_TB_COUNT_LOW),  wr & (paddr_in == `OFS_TA_COUNT_LOW)};
	assign wr_thi  = {wr & (paddr_in == `OFS_TB_COUNT_HIGH), wr & (paddr_in == `OFS_TA_COUNT_HIGH)};
	assign wr_tctl = {wr & (paddr_in == `OFS_TB_CONTROL),    wr & (paddr_in == `OFS_TA_CONTROL)};
	assign wr_vlo  = {wr & (paddr_in == `OFS_U2_VALUE_LOW),  wr & (paddr_in == `OFS_U1_VALUE_LOW)};
	assign wr_vhi  = {wr & (paddr_in == `OFS_U2_VALUE_HIGH), wr & (paddr_in == `OFS_U1_VALUE_HIGH)};
	assign wr_uctl = {wr & (paddr_in == `OFS_U2_CONTROL),    wr & (paddr_in == `OFS_U1_CONTROL)};

	// ==========================================
	// state
	byte_t       flags;
	byte_t       enables;
	byte_t       priorities;
	count_t      cnt   [2];
	byte_t       tctl  [2];
	byte_t       vlo   [2];
	byte_t       vhi   [2];
	byte_t       uctl  [2];
	logic [1:0]  cmp_latch;
	logic [1:0]  eq_q;
	logic [1:0]  match;
	logic [1:0]  sev;
	logic [1:0]  sel;
	logic [1:0]  drives;
	byte_t       mod_period;
	byte_t       mod_count;
	byte_t       mod_ctl;
	logic [1:0]  sub;
	logic [9:0]  duty_shadow;
	logic        pwm_pin;

	// ==========================================
	// time base selection
	// select bits choose time base
	assign sel[0] = tctl[1][`BIT_SEL_HI];
	assign sel[1] = tctl[1][`BIT_SEL_HI] | tctl[1][`BIT_SEL_LO];

	// ==========================================
	// the two timers
	genvar t;
	generate
		for (t = 0; t < 2; t++) begin : g_timer
			wire logic clr = (sev[0] & (sel[0] == 1'(t))) | (sev[1] & (sel[1] == 1'(t)));
			// trigger wins over a same-cycle software write to the count
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					cnt[t] <= 16'h0000;
				end else if (clr) begin
					cnt[t] <= 16'h0000;
				end else if (wr_tlo[t]) begin
					cnt[t][7:0] <= wd;
				end else if (wr_thi[t]) begin
					cnt[t][15:8] <= wd;
				end else if (tctl[t][`BIT_TIMER_ON]) begin
					cnt[t] <= cnt[t] + 16'h0001;
				end
			end
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					tctl[t] <= `RST_BYTE;
				end else if (wr_tctl[t]) begin
					tctl[t] <= wd;
				end
			end
		end
	endgenerate

	// ==========================================
	// the two compare units
	genvar u;
	generate
		for (u = 0; u < 2; u++) begin : g_unit
			wire mode_t  mode  = mode_t'(uctl[u][3:0]);
			wire count_t base  = sel[u] ? cnt[1] : cnt[0];
			wire logic   eq    = (base == {vhi[u], vlo[u]});
			wire logic   pwm   = (u == 1) && (uctl[u][3:2] == 2'b11);
			wire logic   cmpm  = (mode == MODE_TOGGLE_E) || (mode == MODE_SET_HIGH_E) ||
			                     (mode == MODE_SET_LOW_E) || (mode == MODE_SW_IRQ_E) ||
			                     (mode == MODE_SPECIAL_E);
			// a match is the cycle the count reaches the value, so a stopped
			// timer resting on the value fires once, not every cycle
			assign match[u]  = cmpm & eq & ~eq_q[u];
			// trigger pulse in special mode, on both units
			assign sev[u]    = match[u] & (mode == MODE_SPECIAL_E);
			// software interrupt and trigger modes leave the pin on gpio
			assign drives[u] = (mode == MODE_TOGGLE_E) || (mode == MODE_SET_HIGH_E) ||
			                   (mode == MODE_SET_LOW_E) || pwm;
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					eq_q[u] <= 1'b0;
				end else begin
					eq_q[u] <= eq;
				end
			end
			// compare output latch
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					cmp_latch[u] <= 1'b0;
				end else if (wr_uctl[u] && (wd == `RST_BYTE)) begin
					cmp_latch[u] <= 1'b0;
				end else if (match[u]) begin
					case (mode)
						MODE_SET_HIGH_E: cmp_latch[u] <= 1'b1;
						MODE_SET_LOW_E:  cmp_latch[u] <= 1'b0;
						MODE_TOGGLE_E:   cmp_latch[u] <= ~cmp_latch[u];
						default:         cmp_latch[u] <= cmp_latch[u];
					endcase
				end
			end
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					uctl[u] <= `RST_BYTE;
					vlo[u]  <= `RST_BYTE;
				end else begin
					if (wr_uctl[u]) begin
						uctl[u] <= wd & `CTL_IMPL_MASK;
					end
					if (wr_vlo[u]) begin
						vlo[u] <= wd;
					end
				end
			end
			// high byte is read-only while modulating: it shows the latched duty
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					vhi[u] <= `RST_BYTE;
				end else if (pwm) begin
					vhi[u] <= duty_shadow[9:2];
				end else if (wr_vhi[u]) begin
					vhi[u] <= wd;
				end
			end
			// gpio latch passes through when the unit does not own the pin
			assign match_pin_out[u] = drives[u] ? (pwm ? pwm_pin : cmp_latch[u]) :
			                          gpio_latch_in[u];
		end
	endgenerate

	assign special_trigger_out = sev;

	// ==========================================
	// conversion start
	// unit two starts conversion if enabled
	// unit one trigger never reaches the converter
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			adc_start_out <= 1'b0;
		end else begin
			adc_start_out <= sev[1] & adc_enabled_in;
		end
	end

	// ==========================================
	// modulator on unit two
	// the sub counter plays the two low bits below the modulator count, giving 10 bits
	wire logic mod_run  = mod_ctl[`BIT_MOD_ON];
	wire logic pwm_mode = (uctl[1][3:2] == 2'b11);
	wire logic step     = mod_run & (sub == `SUB_LAST);
	wire logic per_end  = step & (mod_count == mod_period);
	wire logic [9:0] duty_new = {vlo[1], uctl[1][5:4]};

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sub <= 2'b00;
		end else if (mod_run) begin
			sub <= sub + 2'b01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mod_count <= `RST_BYTE;
		end else if (wr_mcnt) begin
			mod_count <= wd;
		end else if (per_end) begin
			mod_count <= `RST_BYTE;
		end else if (step) begin
			mod_count <= mod_count + 8'h01;
		end
	end

	// duty latched at period end, double buffered for glitch-free edges
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			duty_shadow <= 10'h000;
		end else if (per_end) begin
			duty_shadow <= duty_new;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pwm_pin <= 1'b0;
		end else if ((wr_uctl[1] && (wd == `RST_BYTE)) || !pwm_mode) begin
			pwm_pin <= 1'b0;
		end else if (per_end) begin
			pwm_pin <= (duty_new != 10'h000);
		end else if (mod_run && ({mod_count, sub} == duty_shadow)) begin
			pwm_pin <= 1'b0;
		end
	end

	// ==========================================
	// interrupt status, enables, priorities
	// flag set with the pin action
	wire byte_t hw_set = ({7'h00, match[0]} << `BIT_U1_IRQ) |
	                     ({7'h00, match[1]} << `BIT_U2_IRQ);
	wire byte_t sw_clr = wr_flags ? wd : `RST_BYTE;
	// only software clears; a set in the same cycle wins
	wire byte_t next_flags = ((flags & ~sw_clr) | hw_set) & `IRQ_IMPL_MASK;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flags      <= `RST_BYTE;
			enables    <= `RST_BYTE;
			priorities <= `RST_BYTE;
		end else begin
			flags <= next_flags;
			if (wr_ena) begin
				enables <= wd & `IRQ_IMPL_MASK;
			end
			if (wr_pri) begin
				priorities <= wd & `IRQ_IMPL_MASK;
			end
		end
	end

	assign irq_out = |(flags & enables);

	// ==========================================
	// modulator registers
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mod_period <= `RST_PERIOD;
			mod_ctl    <= `RST_BYTE;
		end else begin
			if (wr_mper) begin
				mod_period <= wd;
			end
			if (wr_mctl) begin
				mod_ctl <= wd;
			end
		end
	end

	// ==========================================
	// read mux
	logic  hit;
	byte_t rd;
	always_comb begin
		hit = 1'b1;
		case (paddr_in)
			`OFS_IRQ_FLAGS:      rd = flags;
			`OFS_IRQ_ENABLES:    rd = enables;
			`OFS_IRQ_PRIORITIES: rd = priorities;
			`OFS_TA_COUNT_LOW:   rd = cnt[0][7:0];
			`OFS_TA_COUNT_HIGH:  rd = cnt[0][15:8];
			`OFS_TA_CONTROL:     rd = tctl[0];
			`OFS_TB_COUNT_HIGH:  rd = cnt[1][15:8];
			`OFS_TB_COUNT_LOW:   rd = cnt[1][7:0];
			`OFS_TB_CONTROL:     rd = tctl[1];
			`OFS_U1_VALUE_LOW:   rd = vlo[0];
			`OFS_U1_VALUE_HIGH:  rd = vhi[0];
			`OFS_U1_CONTROL:     rd = uctl[0];
			`OFS_U2_VALUE_LOW:   rd = vlo[1];
			`OFS_U2_VALUE_HIGH:  rd = vhi[1];
			`OFS_U2_CONTROL:     rd = uctl[1];
			`OFS_MOD_PERIOD:     rd = mod_period;
			`OFS_MOD_COUNT:      rd = mod_count;
			`OFS_MOD_CONTROL:    rd = mod_ctl;
			default: begin
				rd  = `RST_BYTE;
				hit = 1'b0;
			end
		endcase
	end

	// zero-wait slave; read data is registered on the setup cycle
	assign pready_out  = 1'b1;
	assign pslverr_out = acc & ~hit;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= {24'h00_0000, rd};
		end
	end
endmodule : compare_match_unit
`default_nettype wire

//--- sim/compare_match_unit_assertions.sv
// port-level checker for the compare match unit, bound to its top
`default_nettype none
module compare_match_checker (
	input wire logic        ref_clk_in,
	input wire logic        rstn_in,
	input wire logic [7:0]  paddr_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic [1:0]  gpio_latch_in,
	input wire logic        adc_enabled_in,
	input wire logic        adc_start_out,
	input wire logic [1:0]  match_pin_out,
	input wire logic [1:0]  special_trigger_out,
	input wire logic        irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	// a completed write is the only way software can drop a flag or enable
	wire logic wr_acc = psel_in & penable_in & pwrite_in;

	// ==========================================
	// trigger and conversion start
	a_adc_when_enabled:
		assert property (special_trigger_out[1] && adc_enabled_in |=> adc_start_out)
		else $error("conversion start missing after unit two trigger");
	a_adc_needs_enable:
		assert property (special_trigger_out[1] && !adc_enabled_in |=> !adc_start_out)
		else $error("conversion started with converter off");
	a_adc_unit_two:
		assert property (adc_start_out |-> $past(special_trigger_out[1]))
		else $error("conversion start without unit two trigger");
	a_adc_one_pulse:
		assert property (adc_start_out |=> !adc_start_out)
		else $error("conversion start longer than one cycle");
	a_trig_one_single:
		assert property (special_trigger_out[0] |=> !special_trigger_out[0])
		else $error("unit one trigger longer than one cycle");
	a_trig_two_single:
		assert property (special_trigger_out[1] |=> !special_trigger_out[1])
		else $error("unit two trigger longer than one cycle");

	// ==========================================
	// interrupt and bus
	a_irq_sticky_hold:
		assert property (irq_out && !wr_acc |=> irq_out)
		else $error("interrupt dropped without a write");
	a_irq_clear_write:
		assert property ($fell(irq_out) |-> $past(wr_acc))
		else $error("interrupt fell with no preceding write");
	a_err_access_only:
		assert property (pslverr_out |-> psel_in && penable_in)
		else $error("error response outside access phase");
	a_err_read_zero:
		assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0000_0000)
		else $error("unmapped read returned data");

	// main scenarios reached
	cover property (special_trigger_out[1] ##1 adc_start_out);
	cover property ($rose(irq_out));
	cover property ($rose(match_pin_out[1]) ##[1:40] $fell(match_pin_out[1]));
endmodule : compare_match_checker

bind compare_match_unit compare_match_checker compare_match_checker_inst (
	.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .paddr_in(paddr_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.gpio_latch_in(gpio_latch_in), .adc_enabled_in(adc_enabled_in),
	.adc_start_out(adc_start_out), .match_pin_out(match_pin_out),
	.special_trigger_out(special_trigger_out), .irq_out(irq_out)
);
`default_nettype wire

//--- sim/compare_match_unit_tb_top.sv
// testbench for the compare match unit driven over its register bus
`default_nettype none
`include "compare_match_consts.svh"
module compare_match_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk_in, rstn_in, psel_in, penable_in, pwrite_in, adc_enabled_in;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic        pready_out, pslverr_out, adc_start_out, irq_out, err;
	logic [1:0]  gpio_latch_in, match_pin_out, special_trigger_out;
	int          num_errors, total_checks, period_cycles, high_cycles, periods, i, k, p0;
	int          adc_pulses;
	logic [7:0]  modes [4] = '{8'h08, 8'h09, 8'h02, 8'h08};
	logic        pins [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

	compare_match_unit compare_match_unit_inst (
		.ref_clk_in          (ref_clk_in),
		.rstn_in             (rstn_in),
		.paddr_in            (paddr_in),
		.psel_in             (psel_in),
		.penable_in          (penable_in),
		.pwrite_in           (pwrite_in),
		.pwdata_in           (pwdata_in),
		.prdata_out          (prdata_out),
		.pready_out          (pready_out),
		.pslverr_out         (pslverr_out),
		.gpio_latch_in       (gpio_latch_in),
		.adc_enabled_in      (adc_enabled_in),
		.adc_start_out       (adc_start_out),
		.match_pin_out       (match_pin_out),
		.special_trigger_out (special_trigger_out),
		.irq_out             (irq_out)
	);
	// conversion starts seen at the converter, counted for the trigger checks
	always @(posedge ref_clk_in) begin
		if (adc_start_out === 1'b1) begin
			adc_pulses <= adc_pulses + 1;
		end
	end
	pwm_pin_monitor pwm_pin_monitor_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.pin_in(match_pin_out[1]), .period_cycles(period_cycles),
		.high_cycles(high_cycles), .periods(periods));

	// ==========================================
	// bus tasks: request held until pready is seen at an edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= {24'h00_0000, d};
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do @(posedge ref_clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		cmp(rd, exp);
	endtask : chk_reg
	// polls flags; bounded so a dead unit ends in a mismatch, not a hang
	task automatic wait_flag(input logic [7:0] m);
		rd = '0;
		for (k = 0; k < 60 && (rd[7:0] & m) == 8'h00; k++) xfer(1'b0, `OFS_IRQ_FLAGS, 8'h00);
	endtask : wait_flag
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// whole sequence takes a few hundred cycles
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		num_errors++;
		end_of_test();
	end

	// ==========================================
	// main sequence
	initial begin
		{rstn_in, psel_in, penable_in, pwrite_in, adc_enabled_in} = 5'b0_0000;
		{paddr_in, pwdata_in, gpio_latch_in} = '0;
		repeat (3) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		chk_reg(`OFS_MOD_PERIOD, 32'h0000_00FF);
		chk_reg(8'h48, 32'h0000_0000);
		cmp({31'h0, err}, 32'h0000_0001);
		// timers run from the system clock only
		for (i = 0; i < 4; i++) begin
			wr(`OFS_TA_CONTROL, 8'h00);
			wr(`OFS_TA_COUNT_LOW, 8'h00);
			wr(`OFS_TA_COUNT_HIGH, 8'h00);
			wr(`OFS_U1_VALUE_LOW, 8'h08);
			wr(`OFS_U1_CONTROL, modes[i]);
			wr(`OFS_IRQ_FLAGS, 8'h02);
			wr(`OFS_TA_CONTROL, 8'h01);
			wait_flag(8'h02);
			cmp(rd & 32'h0000_0002, 32'h0000_0002);
			cmp({31'h0, match_pin_out[0]}, {31'h0, pins[i]});
		end
		// zero control: idle pin shows gpio, compare latch restarts low
		gpio_latch_in <= 2'b11;
		wr(`OFS_U1_CONTROL, 8'h00);
		@(posedge ref_clk_in);
		cmp({31'h0, match_pin_out[0]}, 32'h0000_0001);
		wr(`OFS_U1_CONTROL, 8'h02);
		@(posedge ref_clk_in);
		cmp({31'h0, match_pin_out[0]}, 32'h0000_0000);
		// unit two on timer b, software interrupt only
		wr(`OFS_TB_CONTROL, 8'h08);
		wr(`OFS_TB_COUNT_LOW, 8'h00);
		wr(`OFS_U2_VALUE_LOW, 8'h06);
		wr(`OFS_U2_CONTROL, 8'h0A);
		wr(`OFS_TB_CONTROL, 8'h09);
		wait_flag(8'h04);
		cmp(rd & 32'h0000_0004, 32'h0000_0004);
		cmp({30'h0, match_pin_out[1], irq_out}, 32'h0000_0002);
		wr(`OFS_IRQ_ENABLES, 8'h04);
		@(posedge ref_clk_in);
		cmp({31'h0, irq_out}, 32'h0000_0001);
		wr(`OFS_IRQ_FLAGS, 8'h04);
		@(posedge ref_clk_in);
		cmp({31'h0, irq_out}, 32'h0000_0000);
		// special trigger: timer becomes a programmable period
		adc_enabled_in <= 1'b1;
		wr(`OFS_U2_CONTROL, 8'h0B);
		wr(`OFS_TB_COUNT_LOW, 8'h00);
		wait_flag(8'h04);
		chk_reg(`OFS_TB_COUNT_HIGH, 32'h0000_0000);
		cmp({31'h0, adc_pulses != 0}, 32'h0000_0001);
		xfer(1'b0, `OFS_TB_COUNT_LOW, 8'h00);
		cmp({31'h0, rd < 32'h0000_0007}, 32'h0000_0001);
		adc_enabled_in <= 1'b0;
		wr(`OFS_IRQ_FLAGS, 8'h04);
		p0 = adc_pulses;
		wait_flag(8'h04);
		cmp(rd & 32'h0000_0004, 32'h0000_0004);
		cmp(32'(adc_pulses), 32'(p0));
		// unit two idle, so any conversion start now could only come from unit one
		wr(`OFS_U2_CONTROL, 8'h00);
		adc_enabled_in <= 1'b1;
		wr(`OFS_U1_CONTROL, 8'h0B);
		wr(`OFS_U1_VALUE_LOW, 8'h05);
		wr(`OFS_TA_COUNT_HIGH, 8'h00);
		wr(`OFS_TA_COUNT_LOW, 8'h00);
		wr(`OFS_IRQ_FLAGS, 8'h06);
		p0 = adc_pulses;
		wait_flag(8'h02);
		cmp(rd & 32'h0000_0002, 32'h0000_0002);
		cmp(32'(adc_pulses), 32'(p0));
		xfer(1'b0, `OFS_TA_COUNT_LOW, 8'h00);
		cmp({31'h0, rd < 32'h0000_0006}, 32'h0000_0001);
		// modulation: period 4*(3+1) clocks, clear lands one edge after the match
		wr(`OFS_TB_CONTROL, 8'h00);
		wr(`OFS_MOD_PERIOD, 8'h03);
		wr(`OFS_U2_CONTROL, 8'h0C);
		wr(`OFS_MOD_CONTROL, 8'h01);
		for (i = 2; i > 0; i--) begin
			wr(`OFS_U2_VALUE_LOW, i[7:0]);
			p0 = periods;
			for (k = 0; k < 200 && periods < p0 + 3; k++) @(posedge ref_clk_in);
			cmp(32'(period_cycles), 32'h0000_0010);
			cmp(32'(high_cycles), 32'(4 * i + 1));
		end
		// zero duty: pin never set once latched
		wr(`OFS_U2_VALUE_LOW, 8'h00);
		repeat (32) @(posedge ref_clk_in);
		p0 = periods;
		repeat (48) @(posedge ref_clk_in);
		cmp(32'(periods), 32'(p0));
		cmp({31'h0, match_pin_out[1]}, 32'h0000_0000);
		end_of_test();
	end
endmodule : compare_match_unit_tb_top
`default_nettype wire

//--- sim/pwm_pin_monitor.sv
// external circuit on the modulated pin: measures period and high time
`default_nettype none
module pwm_pin_monitor (
	input  wire logic ref_clk_in,
	input  wire logic rstn_in,
	input  wire logic pin_in,
	output var  int   period_cycles,
	output var  int   high_cycles,
	output var  int   periods
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev;
	int   since;
	int   hi_run;

	// pin taken as a driven output
	// each rising edge closes one period; first one is partial
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev <= 1'b0;
			since <= 0;
			hi_run <= 0;
			periods <= 0;
		end else begin
			prev <= pin_in;
			since <= since + 1;
			if (pin_in)
				hi_run <= hi_run + 1;
			if (pin_in && !prev) begin
				period_cycles <= since;
				high_cycles <= hi_run;
				since <= 1;
				hi_run <= 1;
				periods <= periods + 1;
			end
		end
	end
endmodule : pwm_pin_monitor
`default_nettype wire
